/* logic/rlp_pkg.sv */
package rlp_pkg;
  // widths
  localparam int unsigned TIME_W      = 32;
  localparam int unsigned ALARMS      = 3;
  localparam int unsigned EVENTS      = 4;
  localparam int unsigned CAP_W       = 4;
  localparam int unsigned LPC_W       = 16;
  localparam int unsigned MISS_W      = 24;
  // event positions in the flag vectors
  localparam int unsigned EV_ALARM0   = 0;
  localparam int unsigned EV_MISS     = 3;
  // alarm that may clear the time counter
  localparam int unsigned AUTO_ALARM  = 0;
  // reset values
  localparam logic [31:0] TIME_RST    = 32'h0000_0000;
  localparam logic [15:0] LPC_RST     = 16'h0000;
  localparam logic [3:0]  CAP_RST     = 4'h0;
  localparam logic [3:0]  FLAG_RST    = 4'h0;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned MISS_TIME_NS  = 100000;
  // window is a longest time: rounded down
  localparam int unsigned MISS_CYCLES   = MISS_TIME_NS / CLK_PERIOD_NS;
endpackage

/* logic/rlp_lpc.sv */
`timescale 1ns/1ps
module rlp_lpc (
  // clock and reset
  input  wire logic                      clock_i,
  input  wire logic                      rst_n_i,
  // increment sources
  input  wire logic                      tick_i,
  input  wire logic                      ext_edge_i,
  // configuration
  input  wire logic                      enable_i,
  input  wire logic                      src_ext_i,
  input  wire logic                      restart_i,
  input  wire logic                      pwm_en_i,
  input  wire logic [rlp_pkg::LPC_W-1:0] threshold_i,
  input  wire logic [rlp_pkg::LPC_W-1:0] duty_i,
  input  wire logic                      ovf_clr_i,
  input  wire logic                      match_clr_i,
  // state
  output logic      [rlp_pkg::LPC_W-1:0] count_o,
  output logic                           ovf_o,
  output logic                           match_o,
  output logic                           wave_o
);
  logic [rlp_pkg::LPC_W-1:0] cnt_q;
  logic                      ovf_q;
  logic                      match_q;
  logic                      wave_q;
  wire inc_w   = enable_i & (src_ext_i ? ext_edge_i : tick_i);
  wire eq_w    = (cnt_q == threshold_i);
  wire top_w   = &cnt_q;
  wire hit_w   = inc_w & eq_w;
  wire wrap_w  = inc_w & top_w & ~(restart_i & eq_w);
  wire [rlp_pkg::LPC_W-1:0] cnt_d =
    (hit_w & restart_i) ? rlp_pkg::LPC_RST :
    inc_w ? cnt_q + 16'h0001 : cnt_q;
  // pwm level is compared on the count, square wave toggles on match
  wire wave_d = pwm_en_i ? (cnt_q < duty_i) :
                (hit_w ? ~wave_q : wave_q);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q   <= rlp_pkg::LPC_RST;
      ovf_q   <= 1'b0;
      match_q <= 1'b0;
      wave_q  <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      // set beats a simultaneous clear
      ovf_q   <= wrap_w | (ovf_q & ~ovf_clr_i);
      match_q <= hit_w | (match_q & ~match_clr_i);
      wave_q  <= wave_d;
    end
  end

  assign count_o = cnt_q;
  assign ovf_o   = ovf_q;
  assign match_o = match_q;
  assign wave_o  = wave_q;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_hit;
    inc_w && eq_w;
  endsequence
  a_match_flag_set: assert property (s_hit |=> match_q)
    else $error("lpc match flag not set");
  a_ovf_flag_set: assert property (
    (inc_w && top_w && !eq_w) |=> ovf_q)
    else $error("lpc overflow flag not set");
  a_restart_zero: assert property (
    (s_hit and restart_i) |=> cnt_q == 16'h0000)
    else $error("lpc did not restart on match");
  a_count_step: assert property (
    (inc_w && !eq_w) |=> cnt_q == $past(cnt_q) + 16'h0001)
    else $error("lpc count did not advance");
  a_hold_idle: assert property (!inc_w |=> $stable(cnt_q))
    else $error("lpc count moved without increment");
  a_pwm_level: assert property (
    pwm_en_i |=> wave_q == ($past(cnt_q) < $past(duty_i)))
    else $error("lpc pwm level wrong");
  a_square_toggle: assert property (
    (!pwm_en_i and s_hit) |=> wave_q != $past(wave_q))
    else $error("lpc square wave did not toggle");
endmodule // rlp_lpc

/* logic/rlp_top.sv */
`timescale 1ns/1ps
// Notes on behaviour
// - 32-bit time counter advances each rising timer edge
// - three alarm flags plus missing-clock flag
// - each event routable to irq, reset, wakeup
// - alarm zero optionally clears time counter
// - detector flags a stopped timer clock
// - timer clock from internal osc or crystal
// - sixteen-level crystal load capacitance setting
// - timer clock driven to pin when enabled
// - internal oscillator offered to other modules
// - low-power counter runs from timer clock
// - counts timer clock or external edge
// - overflow and threshold match flagged
// - restart on match gives square wave
// - pwm with configurable period and duty
module rlp_top #(
  parameter int unsigned MISS_CYCLES = rlp_pkg::MISS_CYCLES
) (
  // clock and reset
  input  wire logic                       clock_i,
  input  wire logic                       reset_n_i,
  // oscillator and external count pins
  input  wire logic                       int_osc_i,
  input  wire logic                       xtal_i,
  input  wire logic                       ext_count_i,
  // timekeeping unit control
  input  wire logic                       run_en_i,
  input  wire logic                       src_xtal_i,
  input  wire logic                       auto_clr_en_i,
  input  wire logic                       miss_en_i,
  input  wire logic                       clk_out_en_i,
  input  wire logic                       deepest_power_mode_i,
  input  wire logic [rlp_pkg::CAP_W-1:0]  cap_sel_i,
  input  wire logic [rlp_pkg::TIME_W-1:0] alarm0_cmp_i,
  input  wire logic [rlp_pkg::TIME_W-1:0] alarm1_cmp_i,
  input  wire logic [rlp_pkg::TIME_W-1:0] alarm2_cmp_i,
  input  wire logic [rlp_pkg::EVENTS-1:0] flag_clr_i,
  input  wire logic [rlp_pkg::EVENTS-1:0] irq_en_i,
  input  wire logic [rlp_pkg::EVENTS-1:0] rst_en_i,
  input  wire logic [rlp_pkg::EVENTS-1:0] wake_en_i,
  // low-power counter control
  input  wire logic                       lpc_en_i,
  input  wire logic                       lpc_src_ext_i,
  input  wire logic                       lpc_fall_i,
  input  wire logic                       lpc_restart_i,
  input  wire logic                       lpc_pwm_en_i,
  input  wire logic [rlp_pkg::LPC_W-1:0]  lpc_threshold_i,
  input  wire logic [rlp_pkg::LPC_W-1:0]  lpc_duty_i,
  input  wire logic                       lpc_ovf_clr_i,
  input  wire logic                       lpc_match_clr_i,
  // timekeeping unit state
  output logic      [rlp_pkg::TIME_W-1:0] time_o,
  output logic      [rlp_pkg::EVENTS-1:0] flags_o,
  output logic                            irq_o,
  output logic                            sys_reset_req_o,
  output logic                            wake_o,
  // clocks and oscillator setting
  output logic                            timer_clock_out_o,
  output logic                            osc_clk_o,
  output logic      [rlp_pkg::CAP_W-1:0]  cap_sel_o,
  // low-power counter state
  output logic      [rlp_pkg::LPC_W-1:0]  lpc_count_o,
  output logic                            lpc_ovf_o,
  output logic                            lpc_match_o,
  output logic                            lpc_wave_o
);
  // reset release
  logic rst_s1_q;
  logic rst_n_q;
  always_ff @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_s1_q <= 1'b0;
      rst_n_q  <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n_q  <= rst_s1_q;
    end
  end

  // pin synchronisers, first stage read only by second
  logic [2:0] pin_s1_q;
  logic [2:0] pin_s2_q;
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      pin_s1_q <= 3'h0;
      pin_s2_q <= 3'h0;
    end else begin
      pin_s1_q <= {ext_count_i, xtal_i, int_osc_i};
      pin_s2_q <= pin_s1_q;
    end
  end
  wire osc_s_w  = pin_s2_q[0];
  wire xtal_s_w = pin_s2_q[1];
  wire ext_s_w  = pin_s2_q[2];

  // selected timer clock and its rising-edge tick
  wire  sel_clk_d = src_xtal_i ? xtal_s_w : osc_s_w;
  logic sel_clk_q;
  logic sel_prev_q;
  logic ext_prev_q;
  wire  tick_w = sel_clk_q & ~sel_prev_q;
  wire  ext_edge_w = lpc_fall_i ? (~ext_s_w & ext_prev_q)
                                : (ext_s_w & ~ext_prev_q);
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      sel_clk_q  <= 1'b0;
      sel_prev_q <= 1'b0;
      ext_prev_q <= 1'b0;
    end else begin
      sel_clk_q  <= sel_clk_d;
      sel_prev_q <= sel_clk_q;
      ext_prev_q <= ext_s_w;
    end
  end

  function automatic logic hit(input logic [31:0] a,
                               input logic [31:0] b);
    hit = (a == b);
  endfunction

  // time counter and alarms
  logic [rlp_pkg::TIME_W-1:0] time_q;
  wire adv_w = tick_w & run_en_i;
  wire [rlp_pkg::ALARMS-1:0] eq_w = {hit(time_q, alarm2_cmp_i),
                                     hit(time_q, alarm1_cmp_i),
                                     hit(time_q, alarm0_cmp_i)};
  wire [rlp_pkg::ALARMS-1:0] fire_w =
    {rlp_pkg::ALARMS{adv_w}} & eq_w;
  wire auto_w = auto_clr_en_i & fire_w[rlp_pkg::AUTO_ALARM];
  wire [rlp_pkg::TIME_W-1:0] time_d =
    auto_w ? rlp_pkg::TIME_RST :
    adv_w  ? time_q + 32'h0000_0001 : time_q;

  // missing-clock window counter, saturates at the window
  logic [rlp_pkg::MISS_W-1:0] miss_cnt_q;
  wire [rlp_pkg::MISS_W-1:0] miss_lim_w = MISS_CYCLES[23:0] - 24'h000001;
  wire miss_at_w  = (miss_cnt_q == miss_lim_w);
  wire miss_hit_w = miss_en_i & miss_at_w & ~tick_w;
  wire [rlp_pkg::MISS_W-1:0] miss_cnt_d =
    (tick_w | ~miss_en_i) ? 24'h000000 :
    miss_at_w ? miss_cnt_q : miss_cnt_q + 24'h000001;

  // event flags: set beats a simultaneous clear
  logic [rlp_pkg::EVENTS-1:0] flags_q;
  wire [rlp_pkg::EVENTS-1:0] ev_w = {miss_hit_w, fire_w};
  wire [rlp_pkg::EVENTS-1:0] flags_d = ev_w | (flags_q & ~flag_clr_i);
  wire irq_d  = |(flags_q & irq_en_i);
  wire rst_d  = |(flags_q & rst_en_i);
  wire wake_d = |(flags_q & wake_en_i);

  // clock out keeps running in the deepest power mode; the mode
  // pin is not allowed to gate it
  wire clk_out_d = clk_out_en_i & sel_clk_q;
  wire unused_w  = deepest_power_mode_i;

  logic                          irq_q;
  logic                          rst_req_q;
  logic                          wake_q;
  logic                          clk_out_q;
  logic                          osc_out_q;
  logic [rlp_pkg::CAP_W-1:0]     cap_q;
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      time_q     <= rlp_pkg::TIME_RST;
      miss_cnt_q <= 24'h000000;
      flags_q    <= rlp_pkg::FLAG_RST;
    end else begin
      time_q     <= time_d;
      miss_cnt_q <= miss_cnt_d;
      flags_q    <= flags_d;
    end
  end

  // routed requests lag the flags by one edge; kept registered so
  // no pin ever sees a decode glitch
  always_ff @(posedge clock_i or negedge rst_n_q) begin
    if (!rst_n_q) begin
      irq_q      <= 1'b0;
      rst_req_q  <= 1'b0;
      wake_q     <= 1'b0;
      clk_out_q  <= 1'b0;
      osc_out_q  <= 1'b0;
      cap_q      <= rlp_pkg::CAP_RST;
    end else begin
      irq_q      <= irq_d;
      rst_req_q  <= rst_d;
      wake_q     <= wake_d;
      clk_out_q  <= clk_out_d;
      osc_out_q  <= osc_s_w;
      cap_q      <= cap_sel_i;
    end
  end

  assign time_o            = time_q;
  assign flags_o           = flags_q;
  assign irq_o             = irq_q;
  assign sys_reset_req_o   = rst_req_q;
  assign wake_o            = wake_q;
  assign timer_clock_out_o = clk_out_q;
  assign osc_clk_o         = osc_out_q;
  assign cap_sel_o         = cap_q;

  rlp_lpc u_lpc (
    .clock_i     (clock_i),
    .rst_n_i     (rst_n_q),
    .tick_i      (tick_w),
    .ext_edge_i  (ext_edge_w),
    .enable_i    (lpc_en_i),
    .src_ext_i   (lpc_src_ext_i),
    .restart_i   (lpc_restart_i),
    .pwm_en_i    (lpc_pwm_en_i),
    .threshold_i (lpc_threshold_i),
    .duty_i      (lpc_duty_i),
    .ovf_clr_i   (lpc_ovf_clr_i),
    .match_clr_i (lpc_match_clr_i),
    .count_o     (lpc_count_o),
    .ovf_o       (lpc_ovf_o),
    .match_o     (lpc_match_o),
    .wave_o      (lpc_wave_o)
  );

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_q);

  sequence s_alarm_hit(int unsigned i);
    adv_w && eq_w[i];
  endsequence
  sequence s_clock_stopped;
    miss_en_i && miss_at_w && !tick_w;
  endsequence

  a_time_advance: assert property (
    (adv_w && !auto_w) |=> time_q == $past(time_q) + 32'h0000_0001)
    else $error("time counter did not advance on tick");
  a_time_hold: assert property (!adv_w |=> $stable(time_q))
    else $error("time counter moved without tick");
  a_alarm_flag_set: assert property (
    s_alarm_hit(1) |=> flags_q[1] ##1 flags_q[1] || $past(flag_clr_i[1]))
    else $error("alarm flag not set or not sticky");
  a_alarm_sticky: assert property (
    (flags_q[2] && !flag_clr_i[2]) |=> flags_q[2])
    else $error("alarm flag dropped without clear");
  a_auto_clear: assert property (
    (s_alarm_hit(0) and auto_clr_en_i) |=> time_q == 32'h0000_0000)
    else $error("auto clear did not zero the counter");
  a_miss_flag: assert property (
    s_clock_stopped |=> flags_q[rlp_pkg::EV_MISS])
    else $error("missing clock not flagged");
  a_miss_quiet: assert property (
    (tick_w && !flags_q[rlp_pkg::EV_MISS]) |=> !flags_q[rlp_pkg::EV_MISS])
    else $error("missing clock flagged right after an edge");
  a_irq_route: assert property (
    |(flags_q & irq_en_i) |=> irq_o)
    else $error("enabled event did not raise irq");
  a_reset_route: assert property (
    !(|(flags_q & rst_en_i)) |=> !sys_reset_req_o)
    else $error("reset request without enabled event");
  a_clock_out: assert property (
    ##1 timer_clock_out_o == ($past(clk_out_en_i) && $past(sel_clk_q)))
    else $error("timer clock out wrong");
  a_src_select: assert property (
    src_xtal_i |=> sel_clk_q == $past(xtal_s_w))
    else $error("crystal not selected");
  a_cap_level: assert property (
    ##1 cap_sel_o == $past(cap_sel_i))
    else $error("capacitance setting not applied");

  // routing, flag, clock, counter and output checks
  a_wake_route: assert property (
    |(flags_q & wake_en_i) |=> wake_o)
    else $error("enabled event did not raise wakeup");
  a_reset_raise: assert property (
    |(flags_q & rst_en_i) |=> sys_reset_req_o)
    else $error("enabled event did not raise reset request");
  a_irq_quiet: assert property (
    !(|(flags_q & irq_en_i)) |=> !irq_o)
    else $error("irq without enabled event");
  a_flag_clear: assert property (
    (flag_clr_i[0] && !ev_w[0]) |=> !flags_q[0])
    else $error("alarm flag survived its clear");
  a_alarm_refused: assert property (
    (!run_en_i && !(|flags_q[2:0])) |=> !(|flags_q[2:0]))
    else $error("alarm flag set while time counter stopped");
  a_miss_after_edge: assert property (
    tick_w |=> !miss_hit_w)
    else $error("missing clock seen right after an edge");
  a_tick_single: assert property (tick_w |=> !tick_w)
    else $error("timer tick longer than one cycle");
  a_osc_out: assert property (
    ##1 osc_clk_o == $past(osc_s_w))
    else $error("oscillator output does not follow the pin");
  a_osc_select: assert property (
    !src_xtal_i |=> sel_clk_q == $past(osc_s_w))
    else $error("internal oscillator not selected");
  a_out_in_deep: assert property (
    (deepest_power_mode_i && clk_out_en_i)
      |=> timer_clock_out_o == $past(sel_clk_q))
    else $error("clock out stopped in deepest power mode");
  a_auto_only_enabled: assert property (
    (s_alarm_hit(0) and !auto_clr_en_i)
      |=> time_q == $past(time_q) + 32'h0000_0001)
    else $error("time counter cleared with auto clear off");
endmodule // rlp_top

/* verif/rlp_pin_model.sv */
`timescale 1ns/1ps
module rlp_pin_model #(
  parameter int HALF = 4
) (
  // reference clock
  input  wire logic clock_i,
  // run controls
  input  wire logic osc_run_i,
  input  wire logic xtal_run_i,
  input  wire logic ext_run_i,
  // pins
  output logic      int_osc_o,
  output logic      xtal_o,
  output logic      ext_o
);
  int div_q;
  initial begin
    div_q = 0;
    int_osc_o = 1'b0;
    xtal_o = 1'b0;
    ext_o = 1'b0;
  end
  // halted sources always park low, so no half period is left dangling
  always @(posedge clock_i) begin
    div_q <= (div_q == HALF - 1) ? 0 : div_q + 1;
    if (div_q == HALF - 1) begin
      int_osc_o <= int_osc_o ? 1'b0 : osc_run_i;
      xtal_o    <= xtal_o ? 1'b0 : xtal_run_i;
      ext_o     <= ext_o ? 1'b0 : ext_run_i;
    end
  end
endmodule // rlp_pin_model

/* verif/tb_rtc_with_low_power_timer.sv */
`timescale 1ns/1ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin fail_count++; \
  $display("Error at %0t got %0h expected %0h", $time, g, e); end end
module tb_rtc_with_low_power_timer;
  logic        clock_i = 0, reset_n_i = 0;
  wire logic   int_osc_i, xtal_i, ext_count_i;
  logic        run_en_i = 1, src_xtal_i = 1, auto_clr_en_i = 0, miss_en_i = 0;
  logic        clk_out_en_i = 1, deepest_power_mode_i = 1;
  logic [3:0]  cap_sel_i = 0, flag_clr_i = 0, irq_en_i = 0;
  logic [3:0]  rst_en_i = 0, wake_en_i = 0;
  logic        lpc_en_i = 0, lpc_src_ext_i = 0, lpc_fall_i = 0;
  logic        lpc_restart_i = 0, lpc_pwm_en_i = 0;
  logic [15:0] lpc_threshold_i = 0, lpc_duty_i = 0;
  logic        lpc_ovf_clr_i = 0, lpc_match_clr_i = 0;
  logic [31:0] cmp [3] = '{32'hFFFFFFFF, 32'hFFFFFFFF, 32'hFFFFFFFF};
  wire logic [31:0] alarm0_cmp_i = cmp[0];
  wire logic [31:0] alarm1_cmp_i = cmp[1];
  wire logic [31:0] alarm2_cmp_i = cmp[2];
  logic [31:0] time_o;
  logic [3:0]  flags_o, cap_sel_o;
  logic        irq_o, sys_reset_req_o, wake_o, timer_clock_out_o, osc_clk_o;
  logic [15:0] lpc_count_o;
  logic        lpc_ovf_o, lpc_match_o, lpc_wave_o;
  logic        osc_run = 0, xtal_run = 0, ext_run = 0;
  // behavioural model state
  logic [31:0] m_time = 0;
  logic [3:0]  m_flags = 0;
  logic [15:0] m_cnt = 0;
  logic        m_ovf = 0, m_match = 0, m_wave = 0;
  int ticks = 0, osc_edges = 0, co_edges = 0, oc_edges = 0, co_base = 0;
  int fail_count = 0, cmp_count = 0, seed = 28422;

  always #5 clock_i = ~clock_i;

  rlp_top #(.MISS_CYCLES(20)) rlp_top_i (.clock_i, .reset_n_i, .int_osc_i,
    .xtal_i, .ext_count_i, .run_en_i, .src_xtal_i, .auto_clr_en_i, .miss_en_i,
    .clk_out_en_i, .deepest_power_mode_i, .cap_sel_i, .alarm0_cmp_i,
    .alarm1_cmp_i, .alarm2_cmp_i, .flag_clr_i, .irq_en_i, .rst_en_i,
    .wake_en_i, .lpc_en_i, .lpc_src_ext_i, .lpc_fall_i, .lpc_restart_i,
    .lpc_pwm_en_i, .lpc_threshold_i, .lpc_duty_i, .lpc_ovf_clr_i,
    .lpc_match_clr_i, .time_o, .flags_o, .irq_o, .sys_reset_req_o, .wake_o,
    .timer_clock_out_o, .osc_clk_o, .cap_sel_o, .lpc_count_o, .lpc_ovf_o,
    .lpc_match_o, .lpc_wave_o);

  rlp_pin_model #(.HALF(4)) rlp_pin_model_i (.clock_i, .osc_run_i(osc_run),
    .xtal_run_i(xtal_run), .ext_run_i(ext_run), .int_osc_o(int_osc_i),
    .xtal_o(xtal_i), .ext_o(ext_count_i));

  task automatic lpc_step();
    if (lpc_en_i) begin
      if (m_cnt == lpc_threshold_i) begin
        m_match = 1'b1;
        if (!lpc_pwm_en_i) m_wave = ~m_wave;
      end
      if (m_cnt == 16'hFFFF &&
          !(lpc_restart_i && m_cnt == lpc_threshold_i)) m_ovf = 1'b1;
      m_cnt = (lpc_restart_i && m_cnt == lpc_threshold_i) ? 16'h0000
                                                          : m_cnt + 16'h0001;
      if (lpc_pwm_en_i) m_wave = m_cnt < lpc_duty_i;
    end
  endtask

  task automatic tick();
    ticks++;
    if (run_en_i) begin
      for (int k = 0; k < 3; k++) if (m_time == cmp[k]) m_flags[k] = 1'b1;
      m_time = (auto_clr_en_i && m_time == cmp[0]) ? 32'h0 : m_time + 32'h1;
    end
    if (!lpc_src_ext_i) lpc_step();
  endtask

  always @(posedge xtal_i) if (src_xtal_i) tick();
  always @(posedge int_osc_i) begin
    osc_edges++;
    if (!src_xtal_i) tick();
  end
  always @(posedge ext_count_i) if (lpc_src_ext_i && !lpc_fall_i) lpc_step();
  always @(negedge ext_count_i) if (lpc_src_ext_i && lpc_fall_i) lpc_step();
  always @(posedge timer_clock_out_o) co_edges++;
  always @(posedge osc_clk_o) oc_edges++;

  task automatic check_all();
    `CHK(time_o, m_time)
    `CHK(flags_o, m_flags)
    `CHK(irq_o, |(m_flags & irq_en_i))
    `CHK(sys_reset_req_o, |(m_flags & rst_en_i))
    `CHK(wake_o, |(m_flags & wake_en_i))
    `CHK(lpc_count_o, m_cnt)
    `CHK(lpc_match_o, m_match)
    `CHK(lpc_ovf_o, m_ovf)
    `CHK(lpc_wave_o, m_wave)
  endtask

  // sources run only between config changes, so the model never races
  task automatic run(input int n, input logic x, input logic o, input logic e);
    @(negedge clock_i);
    xtal_run = x;
    osc_run = o;
    ext_run = e;
    repeat (n * 8) @(negedge clock_i);
    xtal_run = 0;
    osc_run = 0;
    ext_run = 0;
    repeat (16) @(negedge clock_i);
    check_all();
  endtask

  task automatic clr(input logic [3:0] m, input logic l);
    @(negedge clock_i);
    flag_clr_i = m;
    lpc_match_clr_i = l;
    lpc_ovf_clr_i = l;
    @(negedge clock_i);
    flag_clr_i = 0;
    lpc_match_clr_i = 0;
    lpc_ovf_clr_i = 0;
    m_flags &= ~m;
    if (l) begin
      m_match = 0;
      m_ovf = 0;
    end
    repeat (3) @(negedge clock_i);
    check_all();
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  initial begin
    #300000;
    fail_count++;
    give_verdict();
  end

  initial begin
    repeat (6) @(posedge clock_i);
    @(negedge clock_i) reset_n_i = 1;
    repeat (5) @(negedge clock_i);
    for (int v = 0; v < 16; v++) begin
      cap_sel_i = 4'(v);
      repeat (2) @(negedge clock_i);
      `CHK(cap_sel_o, cap_sel_i)
    end
    $display("capacitance test done");
    for (int k = 0; k < 3; k++)
      cmp[k] = 32'd3 + 32'(k * 5) + ($random(seed) & 32'h3);
    irq_en_i = 4'($random(seed)) & 4'h7;
    rst_en_i = 4'($random(seed)) & 4'h7;
    wake_en_i = 4'($random(seed)) & 4'h7;
    run(10, 1, 0, 0);
    src_xtal_i = 0;
    run(12, 0, 1, 0);
    `CHK(co_edges, ticks)
    `CHK(oc_edges, osc_edges)
    clr(4'h7, 1'b0);
    run_en_i = 0;
    clk_out_en_i = 0;
    co_base = co_edges;
    run(4, 0, 1, 0);
    `CHK(co_edges, co_base)
    run_en_i = 1;
    clk_out_en_i = 1;
    $display("alarm test done");
    auto_clr_en_i = 1;
    src_xtal_i = 1;
    cmp[0] = m_time + 32'd4 + ($random(seed) & 32'h3);
    run(20, 1, 0, 0);
    auto_clr_en_i = 0;
    clr(4'h7, 1'b0);
    $display("auto clear test done");
    irq_en_i = 4'h8;
    miss_en_i = 1;
    xtal_run = 1;
    repeat (60) @(negedge clock_i);
    `CHK(flags_o[3], 1'b0)
    xtal_run = 0;
    repeat (40) @(negedge clock_i);
    m_flags[3] = 1'b1;
    check_all();
    miss_en_i = 0;
    clr(4'hF, 1'b0);
    $display("missing clock test done");
    lpc_en_i = 1;
    lpc_restart_i = 1;
    lpc_threshold_i = 16'h0003 + 16'($random(seed) & 3);
    run(24, 1, 0, 0);
    clr(4'h7, 1'b1);
    lpc_src_ext_i = 1;
    run(10, 0, 0, 1);
    lpc_fall_i = 1;
    run(10, 0, 0, 1);
    lpc_src_ext_i = 0;
    lpc_pwm_en_i = 1;
    lpc_threshold_i = 16'h0007;
    lpc_duty_i = 16'h0003;
    for (int i = 0; i < 6; i++) run(i + 1, 1, 0, 0);
    $display("low power counter test done");
    give_verdict();
  end
endmodule // tb_rtc_with_low_power_timer
